//--- pmc_pkg.sv
// Constants, offsets and field layouts of the misc register set.
package pmc_pkg;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int ADC_W = 10;
   localparam int SCRATCH_STD_N = 8;
   localparam int SCRATCH_EXT_N = 16;
   localparam int SCRATCH_N = SCRATCH_STD_N + SCRATCH_EXT_N;
   localparam int IDX_W = 5;
   localparam int DRIVE_FIELDS = 9;
   // Register offsets.
   localparam logic [8:0] OFS_CHIP1_IDENTITY = 9'h000;
   localparam logic [8:0] OFS_CHIP2_IDENTITY = 9'h001;
   localparam logic [8:0] OFS_IDENTITY_RESERVED_A = 9'h002;
   localparam logic [8:0] OFS_IDENTITY_RESERVED_B = 9'h003;
   localparam logic [8:0] OFS_RAIL_CONTROL = 9'h0C0;
   localparam logic [8:0] OFS_SCRATCH_STD_BASE = 9'h0D0;
   localparam logic [8:0] OFS_SCRATCH_EXT_BASE = 9'h1A0;
   localparam logic [8:0] OFS_PIN_DRIVE_CONTROL_A = 9'h1BF;
   localparam logic [8:0] OFS_PIN_DRIVE_CONTROL_B = 9'h1C0;
   localparam logic [8:0] OFS_PIN_DRIVE_CONTROL_C = 9'h1C1;
   // Reset values.
   localparam logic [7:0] RST_DRIVE_A = 8'h00;
   localparam logic [7:0] RST_DRIVE_B = 8'h04;
   localparam logic [1:0] RST_DRIVE_C = 2'h1;
   // Identity layout.
   localparam int VENDOR_LSB = 0;
   localparam int REVISION_LSB = 3;
   // Rail control bit positions.
   localparam int RAIL_EN_BIT = 0;
   localparam int RAIL_FAULT_BIT = 1;
   localparam int RAIL_TRIP_BIT = 2;
   localparam int RAIL_ON_BIT = 3;
   // Drive codes.
   localparam logic [1:0] DRIVE_HIZ = 2'h2;
   // Companion settle time before its status is believed.
   localparam int CLK_PERIOD_NS = 10;
   localparam int RAIL_SETTLE_NS = 1000;
   localparam int RAIL_SETTLE_CYCLES =
      (RAIL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W = 8;
endpackage : pmc_pkg

//--- pmc_scratch.sv
// Retained scratch memory, cleared only by the real-time-clock reset.
`timescale 1ns/100ps
module pmc_scratch import pmc_pkg::*; #(
   parameter int DEPTH = SCRATCH_N
) (
   input wire logic clk_in,
   input wire logic rtc_rst_n_in,
   input wire logic wr_en_in,
   input wire logic [IDX_W-1:0] wr_idx_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic [IDX_W-1:0] rd_idx_in,
   output logic [DATA_W-1:0] rd_data_out
);
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] next_mem [DEPTH];

   // Next contents: only the addressed byte changes.
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         next_mem[i] = mem[i];
      end
      if (wr_en_in) begin
         next_mem[wr_idx_in] = wr_data_in;
      end
   end

   // The system reset never reaches here, so contents survive it.
   always_ff @(posedge clk_in or negedge rtc_rst_n_in) begin
      if (!rtc_rst_n_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= 8'h00;
         end
      end else begin
         mem <= next_mem;
      end
   end

   // Read is combinational; the caller registers it.
   assign rd_data_out = mem[rd_idx_in];

   property p_scratch_keeps;
      @(posedge clk_in) disable iff (!rtc_rst_n_in)
      wr_en_in |=> mem[$past(wr_idx_in)] == $past(wr_data_in);
   endproperty
   a_scratch_keeps: assert property (p_scratch_keeps)
      else $error("Scratch byte did not take the written value.");
endmodule : pmc_scratch

//--- pmc_misc_regs.sv
// Misc register set with companion rail control and pin drive settings.
`timescale 1ns/100ps
module pmc_misc_regs import pmc_pkg::*; #(
   parameter logic [2:0] CHIP1_VENDOR = 3'h5, // Arbitrary value.
   parameter logic [2:0] CHIP1_REVISION = 3'h2, // Arbitrary value.
   parameter logic [2:0] CHIP2_VENDOR = 3'h3, // Arbitrary value.
   parameter logic [2:0] CHIP2_REVISION = 3'h1, // Arbitrary value.
   parameter int SETTLE_CYCLES = RAIL_SETTLE_CYCLES
) (
   input wire logic MCLK_IN,
   input wire logic RESET_N_IN,
   input wire logic RTC_POWER_ON_RESET_N_IN,
   input wire logic [ADDR_W-1:0] REG_ADDR_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [DATA_W-1:0] REG_WDATA_IN,
   output logic [DATA_W-1:0] REG_RDATA_OUT,
   output logic REG_RVALID_OUT,
   input wire logic THERMAL_TRIP_N_IN,
   input wire logic COMPANION_RAIL_STATUS_N_IN,
   input wire logic [ADC_W-1:0] COMPANION_CURRENT_SENSE_IN,
   output logic [ADC_W-1:0] ADC_COMPANION_SAMPLE_OUT,
   output logic COMPANION_RAIL_ENABLE_OUT,
   output logic REGULATOR_FAULT_IRQ_OUT,
   output logic [1:0] POWER_GOOD_DRIVE_SEL_OUT,
   output logic [1:0] COMP_TOGGLE_DRIVE_SEL_OUT,
   output logic [1:0] IRQ_OUT_DRIVE_SEL_OUT,
   output logic [1:0] RESET_OUT_DRIVE_SEL_OUT,
   output logic [1:0] SLOW_CLOCK_DRIVE_SEL_OUT,
   output logic [1:0] AUDIO_CLOCK_DRIVE_SEL_OUT,
   output logic [1:0] AUX_ENABLE_DRIVE_SEL_OUT,
   output logic [1:0] COMPANION_ENABLE_DRIVE_SEL_OUT,
   output logic [1:0] SERIAL_OUT_DRIVE_SEL_OUT,
   output logic [DRIVE_FIELDS-1:0] PIN_DRIVE_OE_OUT
);
   localparam logic [7:0] CHIP1_ID =
      {2'h0, CHIP1_REVISION, CHIP1_VENDOR};
   localparam logic [7:0] CHIP2_ID =
      {2'h0, CHIP2_REVISION, CHIP2_VENDOR};
   localparam logic [SETTLE_W-1:0] SETTLE_MAX = SETTLE_W'(SETTLE_CYCLES);

   logic sys_meta, sys_rst_n;
   logic rtc_meta, rtc_rst_n;

   // Reset release synchronisers; assertion stays asynchronous.
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         sys_meta <= 1'b0;
         sys_rst_n <= 1'b0;
      end else begin
         sys_meta <= 1'b1;
         sys_rst_n <= sys_meta;
      end
   end

   always_ff @(posedge MCLK_IN or negedge RTC_POWER_ON_RESET_N_IN) begin
      if (!RTC_POWER_ON_RESET_N_IN) begin
         rtc_meta <= 1'b0;
         rtc_rst_n <= 1'b0;
      end else begin
         rtc_meta <= 1'b1;
         rtc_rst_n <= rtc_meta;
      end
   end

   // Address decode.
   logic [ADDR_W-1:0] std_off, ext_off;
   logic std_hit, ext_hit;
   logic [IDX_W-1:0] scratch_idx;
   logic [DATA_W-1:0] scratch_rd;
   logic wr_rail, wr_drv_a, wr_drv_b, wr_drv_c;

   // Standard bytes map to entries 0..7, extended ones to 8..23.
   always_comb begin
      std_off = REG_ADDR_IN - OFS_SCRATCH_STD_BASE;
      ext_off = REG_ADDR_IN - OFS_SCRATCH_EXT_BASE;
      std_hit = (std_off < ADDR_W'(SCRATCH_STD_N));
      ext_hit = (ext_off < ADDR_W'(SCRATCH_EXT_N));
      if (std_hit) begin
         scratch_idx = std_off[IDX_W-1:0];
      end else begin
         scratch_idx = ext_off[IDX_W-1:0] + IDX_W'(SCRATCH_STD_N);
      end
      wr_rail = REG_WR_IN && (REG_ADDR_IN == OFS_RAIL_CONTROL);
      wr_drv_a = REG_WR_IN && (REG_ADDR_IN == OFS_PIN_DRIVE_CONTROL_A);
      wr_drv_b = REG_WR_IN && (REG_ADDR_IN == OFS_PIN_DRIVE_CONTROL_B);
      wr_drv_c = REG_WR_IN && (REG_ADDR_IN == OFS_PIN_DRIVE_CONTROL_C);
   end

   pmc_scratch #(
      .DEPTH(SCRATCH_N)
   ) u_scratch (
      .clk_in(MCLK_IN),
      .rtc_rst_n_in(rtc_rst_n),
      .wr_en_in(REG_WR_IN && (std_hit || ext_hit)),
      .wr_idx_in(scratch_idx),
      .wr_data_in(REG_WDATA_IN),
      .rd_idx_in(scratch_idx),
      .rd_data_out(scratch_rd)
   );

   // Companion rail state.
   logic rail_req, next_rail_req;
   logic rail_en, next_rail_en;
   logic fault, next_fault;
   logic [SETTLE_W-1:0] settle, next_settle;
   logic armed, fault_event;

   // A trip clears the request too, so the rail stays off afterwards
   // until software asks for it again; the trip beats the write.
   always_comb begin
      armed = (settle == SETTLE_MAX);
      fault_event = rail_en && armed && COMPANION_RAIL_STATUS_N_IN;
      next_rail_req = rail_req;
      if (wr_rail) begin
         next_rail_req = REG_WDATA_IN[RAIL_EN_BIT];
      end
      if (!THERMAL_TRIP_N_IN) begin
         next_rail_req = 1'b0;
      end
      next_rail_en = next_rail_req && THERMAL_TRIP_N_IN;
      // Status is ignored until the companion had time to come up.
      if (!rail_en) begin
         next_settle = '0;
      end else if (!armed) begin
         next_settle = settle + SETTLE_W'(1);
      end else begin
         next_settle = settle;
      end
      next_fault = fault;
      if (wr_rail && REG_WDATA_IN[RAIL_FAULT_BIT]) begin
         next_fault = 1'b0;
      end
      if (fault_event) begin
         next_fault = 1'b1;
      end
   end

   always_ff @(posedge MCLK_IN or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         rail_req <= 1'b0;
         rail_en <= 1'b0;
         fault <= 1'b0;
         settle <= '0;
      end else begin
         rail_req <= next_rail_req;
         rail_en <= next_rail_en;
         fault <= next_fault;
         settle <= next_settle;
      end
   end

   assign COMPANION_RAIL_ENABLE_OUT = rail_en;
   assign REGULATOR_FAULT_IRQ_OUT = fault;

   // Drive-control registers; reserved bits are never stored.
   logic [7:0] drv_a, next_drv_a, drv_b, next_drv_b;
   logic [1:0] drv_c, next_drv_c;
   logic [2*DRIVE_FIELDS-1:0] next_fields;
   logic [DRIVE_FIELDS-1:0] oe, next_oe;

   always_comb begin
      next_drv_a = wr_drv_a ? REG_WDATA_IN : drv_a;
      next_drv_b = wr_drv_b ? REG_WDATA_IN : drv_b;
      next_drv_c = wr_drv_c ? REG_WDATA_IN[1:0] : drv_c;
      next_fields = {next_drv_c, next_drv_b, next_drv_a};
   end

   // Enables come from the next value so they flip with the field.
   for (genvar i = 0; i < DRIVE_FIELDS; i++) begin : g_oe
      assign next_oe[i] = (next_fields[2*i +: 2] != DRIVE_HIZ);
   end

   always_ff @(posedge MCLK_IN or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         drv_a <= RST_DRIVE_A;
         drv_b <= RST_DRIVE_B;
         drv_c <= RST_DRIVE_C;
         oe <= '1;
      end else begin
         drv_a <= next_drv_a;
         drv_b <= next_drv_b;
         drv_c <= next_drv_c;
         oe <= next_oe;
      end
   end

   assign POWER_GOOD_DRIVE_SEL_OUT = drv_a[1:0];
   assign COMP_TOGGLE_DRIVE_SEL_OUT = drv_a[3:2];
   assign IRQ_OUT_DRIVE_SEL_OUT = drv_a[5:4];
   assign RESET_OUT_DRIVE_SEL_OUT = drv_a[7:6];
   assign SLOW_CLOCK_DRIVE_SEL_OUT = drv_b[1:0];
   assign AUDIO_CLOCK_DRIVE_SEL_OUT = drv_b[3:2];
   assign AUX_ENABLE_DRIVE_SEL_OUT = drv_b[5:4];
   assign COMPANION_ENABLE_DRIVE_SEL_OUT = drv_b[7:6];
   assign SERIAL_OUT_DRIVE_SEL_OUT = drv_c;
   assign PIN_DRIVE_OE_OUT = oe;

   // Read path and current-sense sample, one cycle of latency.
   logic [DATA_W-1:0] rdata, next_rdata;
   logic rvalid;
   logic [ADC_W-1:0] sense;

   always_comb begin
      next_rdata = rdata;
      if (REG_RD_IN) begin
         next_rdata = 8'h00; // Unmapped reads return zero.
         if (std_hit || ext_hit) begin
            next_rdata = scratch_rd;
         end
         unique case (REG_ADDR_IN)
            OFS_CHIP1_IDENTITY: next_rdata = CHIP1_ID;
            OFS_CHIP2_IDENTITY: next_rdata = CHIP2_ID;
            OFS_IDENTITY_RESERVED_A: next_rdata = 8'h00;
            OFS_IDENTITY_RESERVED_B: next_rdata = 8'h00;
            OFS_RAIL_CONTROL: begin
               next_rdata = 8'h00;
               next_rdata[RAIL_EN_BIT] = rail_req;
               next_rdata[RAIL_FAULT_BIT] = fault;
               next_rdata[RAIL_TRIP_BIT] = !THERMAL_TRIP_N_IN;
               next_rdata[RAIL_ON_BIT] = !COMPANION_RAIL_STATUS_N_IN;
            end
            OFS_PIN_DRIVE_CONTROL_A: next_rdata = drv_a;
            OFS_PIN_DRIVE_CONTROL_B: next_rdata = drv_b;
            OFS_PIN_DRIVE_CONTROL_C: next_rdata = {6'h00, drv_c};
            default: ;
         endcase
      end
   end

   always_ff @(posedge MCLK_IN or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         rdata <= 8'h00;
         rvalid <= 1'b0;
         sense <= '0;
      end else begin
         rdata <= next_rdata;
         rvalid <= REG_RD_IN;
         sense <= COMPANION_CURRENT_SENSE_IN;
      end
   end

   assign REG_RDATA_OUT = rdata;
   assign REG_RVALID_OUT = rvalid;
   assign ADC_COMPANION_SAMPLE_OUT = sense;

   property p_enable_follows;
      @(posedge MCLK_IN) disable iff (!sys_rst_n)
      (wr_rail && REG_WDATA_IN[RAIL_EN_BIT] && THERMAL_TRIP_N_IN)
         |=> COMPANION_RAIL_ENABLE_OUT;
   endproperty
   a_enable_follows: assert property (p_enable_follows)
      else $error("Rail enable did not follow the control write.");

   property p_trip_kills;
      @(posedge MCLK_IN) disable iff (!sys_rst_n)
      !THERMAL_TRIP_N_IN |=> !COMPANION_RAIL_ENABLE_OUT && !rail_req;
   endproperty
   a_trip_kills: assert property (p_trip_kills)
      else $error("Rail stayed enabled during a thermal trip.");

   property p_fault_sets;
      @(posedge MCLK_IN) disable iff (!sys_rst_n)
      (COMPANION_RAIL_ENABLE_OUT && armed && COMPANION_RAIL_STATUS_N_IN)
         |=> REGULATOR_FAULT_IRQ_OUT;
   endproperty
   a_fault_sets: assert property (p_fault_sets)
      else $error("Rail loss did not raise the fault output.");

   property p_fault_sticky;
      @(posedge MCLK_IN) disable iff (!sys_rst_n)
      REGULATOR_FAULT_IRQ_OUT && !wr_rail |=> REGULATOR_FAULT_IRQ_OUT;
   endproperty
   a_fault_sticky: assert property (p_fault_sticky)
      else $error("Fault output dropped without a clear.");

   property p_id_read;
      @(posedge MCLK_IN) disable iff (!sys_rst_n)
      REG_RD_IN && REG_ADDR_IN == OFS_CHIP1_IDENTITY
         |=> REG_RVALID_OUT && REG_RDATA_OUT == CHIP1_ID;
   endproperty
   a_id_read: assert property (p_id_read)
      else $error("Identity read returned a wrong value.");

   property p_id_reserved;
      @(posedge MCLK_IN) disable iff (!sys_rst_n)
      REG_RD_IN && (REG_ADDR_IN == OFS_IDENTITY_RESERVED_A ||
         REG_ADDR_IN == OFS_IDENTITY_RESERVED_B) |=> REG_RDATA_OUT == 8'h00;
   endproperty
   a_id_reserved: assert property (p_id_reserved)
      else $error("Reserved identity word read nonzero.");

   property p_drive_write;
      @(posedge MCLK_IN) disable iff (!sys_rst_n)
      wr_drv_a |=> POWER_GOOD_DRIVE_SEL_OUT == $past(REG_WDATA_IN[1:0])
         && RESET_OUT_DRIVE_SEL_OUT == $past(REG_WDATA_IN[7:6]);
   endproperty
   a_drive_write: assert property (p_drive_write)
      else $error("Drive field did not take the written code.");

   property p_hiz;
      @(posedge MCLK_IN) disable iff (!sys_rst_n)
      PIN_DRIVE_OE_OUT[7] == (COMPANION_ENABLE_DRIVE_SEL_OUT != DRIVE_HIZ);
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("Output enable disagrees with the drive code.");

   // A write in the read cycle must not leak into the returned code.
   property p_rsvd_c;
      @(posedge MCLK_IN) disable iff (!sys_rst_n)
      REG_RD_IN && REG_ADDR_IN == OFS_PIN_DRIVE_CONTROL_C
         |=> REG_RDATA_OUT[7:2] == 6'h00 &&
         REG_RDATA_OUT[1:0] == $past(SERIAL_OUT_DRIVE_SEL_OUT);
   endproperty
   a_rsvd_c: assert property (p_rsvd_c)
      else $error("Reserved bits of the third drive register read set.");
endmodule : pmc_misc_regs

//--- pmc_companion_model.sv
// Behavioural model of the companion 3.3 V regulator on the pin side.
`timescale 1ns/100ps
module pmc_companion_model #(
   parameter int RAMP = 3
) (
   input wire logic clk_in,
   input wire logic enable_in,
   input wire logic fault_in,
   output logic status_n_out
);
   int ramp_count;

   // The rail comes up only after the enable has been held for the ramp.
   // A commanded local fault drops it at once, as an over-heat trip would.
   always_ff @(posedge clk_in) begin
      if (!enable_in || fault_in) begin
         ramp_count <= 0;
      end else if (ramp_count < RAMP) begin
         ramp_count <= ramp_count + 1;
      end
   end

   // Status is low only while the output is really up.
   assign status_n_out = !(enable_in && !fault_in && ramp_count == RAMP);
endmodule : pmc_companion_model

//--- pmc_misc_regs_tb.sv
// Self-checking testbench of the misc register set and rail control.
`timescale 1ns/100ps
module pmc_misc_regs_tb import pmc_pkg::*; ;
   localparam logic [2:0] C1V = 3'h5; // Arbitrary value.
   localparam logic [2:0] C1R = 3'h2; // Arbitrary value.
   localparam logic [2:0] C2V = 3'h3; // Arbitrary value.
   localparam logic [2:0] C2R = 3'h1; // Arbitrary value.
   localparam logic [7:0] CHIP1_ID_EXP = {2'h0, C1R, C1V};
   localparam logic [7:0] CHIP2_ID_EXP = {2'h0, C2R, C2V};
   localparam int SETTLE = 4;
   typedef struct packed {
      logic [8:0] addr;
      logic wr;
      logic [7:0] wd;
      logic [7:0] exp;
   } pmc_row_s;
   logic mclk, reset_n, rtc_n, reg_wr, reg_rd, trip_n, fault;
   logic [8:0] addr;
   logic [7:0] wdata, got, rdata;
   logic [9:0] sense, sample;
   logic rvalid, rail_en, irq, status_n;
   logic [1:0] pg_sel, ct_sel, iq_sel, rs_sel, sc_sel, ac_sel, ax_sel;
   logic [1:0] ce_sel, so_sel;
   logic [8:0] oe;
   int err_count = 0;
   int total_checks = 0;
   pmc_row_s rows [0:12] = '{
      '{9'h000, 1'h0, 8'h00, CHIP1_ID_EXP},
      '{9'h000, 1'h1, 8'hFF, CHIP1_ID_EXP},
      '{9'h001, 1'h1, 8'hFF, CHIP2_ID_EXP}, '{9'h002, 1'h1, 8'hFF, 8'h00},
      '{9'h003, 1'h0, 8'h00, 8'h00}, '{9'h1BF, 1'h1, 8'hE4, 8'hE4},
      '{9'h1C1, 1'h1, 8'hFF, 8'h03}, '{9'h0D0, 1'h1, 8'hA5, 8'hA5},
      '{9'h0D7, 1'h1, 8'h5A, 8'h5A}, '{9'h1A0, 1'h1, 8'h3C, 8'h3C},
      '{9'h1AF, 1'h1, 8'hC3, 8'hC3}, '{9'h0D8, 1'h1, 8'h77, 8'h00},
      '{9'h1B0, 1'h1, 8'h77, 8'h00}};

   pmc_misc_regs #(.CHIP1_VENDOR(C1V), .CHIP1_REVISION(C1R),
      .CHIP2_VENDOR(C2V), .CHIP2_REVISION(C2R), .SETTLE_CYCLES(SETTLE)) u_dut (
      .MCLK_IN(mclk), .RESET_N_IN(reset_n), .RTC_POWER_ON_RESET_N_IN(rtc_n),
      .REG_ADDR_IN(addr), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
      .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
      .THERMAL_TRIP_N_IN(trip_n), .COMPANION_RAIL_STATUS_N_IN(status_n),
      .COMPANION_CURRENT_SENSE_IN(sense), .ADC_COMPANION_SAMPLE_OUT(sample),
      .COMPANION_RAIL_ENABLE_OUT(rail_en), .REGULATOR_FAULT_IRQ_OUT(irq),
      .POWER_GOOD_DRIVE_SEL_OUT(pg_sel), .COMP_TOGGLE_DRIVE_SEL_OUT(ct_sel),
      .IRQ_OUT_DRIVE_SEL_OUT(iq_sel), .RESET_OUT_DRIVE_SEL_OUT(rs_sel),
      .SLOW_CLOCK_DRIVE_SEL_OUT(sc_sel), .AUDIO_CLOCK_DRIVE_SEL_OUT(ac_sel),
      .AUX_ENABLE_DRIVE_SEL_OUT(ax_sel),
      .COMPANION_ENABLE_DRIVE_SEL_OUT(ce_sel),
      .SERIAL_OUT_DRIVE_SEL_OUT(so_sel), .PIN_DRIVE_OE_OUT(oe));

   pmc_companion_model #(.RAMP(3)) u_comp (.clk_in(mclk),
      .enable_in(rail_en), .fault_in(fault), .status_n_out(status_n));

   // Free-running 100 MHz clock.
   initial begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end

   task end_sim;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   task chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk_reg

   task chk_pin(input string nm, input logic [9:0] e, input logic [9:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk_pin

   // Inputs move 1 ns after the edge so the design never races the bench.
   task step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step

   task wr(input logic [8:0] a, input logic [7:0] d);
      step(1);
      reg_wr = 1'h1;
      addr = a;
      wdata = d;
      step(1);
      reg_wr = 1'h0;
   endtask : wr

   task rd(input logic [8:0] a);
      step(1);
      reg_rd = 1'h1;
      addr = a;
      step(1);
      reg_rd = 1'h0;
      chk_pin("rvalid", 10'h001, {9'h000, rvalid});
      got = rdata;
   endtask : rd

   // Bounded wait for the fault line; a miss ends the run at once.
   task wait_irq(input int bound);
      int n;
      n = 0;
      while (irq !== 1'h1 && n < bound) begin
         step(1);
         n++;
      end
      total_checks++;
      if (irq !== 1'h1) begin
         err_count++;
         $display("BAD irq_wait exp 1 got %b", irq);
         end_sim();
      end
   endtask : wait_irq

   // Watchdog so that a stuck sequence still reaches the verdict.
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      $display("BAD watchdog exp done got hang");
      end_sim();
   end

   // Main sequence: table of plain accesses, then the awkward cases.
   initial begin
      {reset_n, rtc_n, reg_wr, reg_rd, fault} = 5'h00;
      trip_n = 1'h1;
      addr = 9'h000;
      wdata = 8'h00;
      sense = 10'h000;
      step(6);
      {reset_n, rtc_n} = 2'h3;
      step(3);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            wr(rows[i].addr, rows[i].wd);
         end
         rd(rows[i].addr);
         chk_reg("row_read", rows[i].exp, got);
      end
      chk_pin("field_set", 10'h01B, {4'h0, ct_sel, iq_sel, rs_sel});
      chk_pin("oe_a", 10'h000, {9'h000, oe[2]});
      // System reset keeps scratch but restores the drive registers.
      reset_n = 1'h0;
      step(6);
      reset_n = 1'h1;
      step(3);
      chk_pin("drv_rst", 10'h005, {2'h0, ax_sel, sc_sel, ac_sel, so_sel});
      chk_pin("oe_rst", 10'h1FF, {1'h0, oe});
      rd(OFS_PIN_DRIVE_CONTROL_B);
      chk_reg("drv_b_rst", 8'h04, got);
      rd(OFS_PIN_DRIVE_CONTROL_C);
      chk_reg("drv_c_rst", 8'h01, got);
      rd(OFS_SCRATCH_STD_BASE);
      chk_reg("keep_std", 8'hA5, got);
      // Only the real-time-clock reset wipes the retained bytes.
      rtc_n = 1'h0;
      step(6);
      rtc_n = 1'h1;
      step(3);
      rd(9'h1AF);
      chk_reg("wipe_ext", 8'h00, got);
      for (int c = 0; c < 4; c++) begin
         wr(OFS_PIN_DRIVE_CONTROL_A, {6'h00, c[1:0]});
         chk_pin("pg_sel", {8'h00, c[1:0]}, {8'h00, pg_sel});
         chk_pin("oe_pg", {9'h000, c != 2}, {9'h000, oe[0]});
         wr(OFS_PIN_DRIVE_CONTROL_B, {c[1:0], c[1:0], 4'h4});
         chk_pin("ce_sel", {4'h0, c[1:0], c[1:0], 2'h1},
            {4'h0, ce_sel, ax_sel, ac_sel});
         chk_pin("oe_ce", {8'h00, c != 2, c != 2},
            {8'h00, oe[7], oe[6]});
      end
      wr(OFS_PIN_DRIVE_CONTROL_C, 8'h02);
      chk_pin("so_oe", 10'h002, {8'h00, so_sel[1], oe[8]});
      // Rail on, settle, then a local fault from the companion.
      wr(OFS_RAIL_CONTROL, 8'h01);
      chk_pin("rail_on", 10'h001, {9'h000, rail_en});
      step(SETTLE + 6);
      chk_pin("irq_quiet", 10'h000, {9'h000, irq});
      rd(OFS_RAIL_CONTROL);
      chk_reg("rail_ctl", 8'h09, got);
      fault = 1'h1;
      wait_irq(8);
      wr(OFS_RAIL_CONTROL, 8'h03);
      step(1);
      chk_pin("irq_held", 10'h001, {9'h000, irq});
      fault = 1'h0;
      step(6);
      wr(OFS_RAIL_CONTROL, 8'h03);
      step(1);
      chk_pin("irq_clr", 10'h000, {9'h000, irq});
      // A thermal trip drops the rail and it stays down afterwards.
      trip_n = 1'h0;
      step(1);
      chk_pin("trip_off", 10'h000, {9'h000, rail_en});
      step(4);
      chk_pin("irq_trip", 10'h000, {9'h000, irq});
      trip_n = 1'h1;
      step(2);
      chk_pin("stay_off", 10'h000, {9'h000, rail_en});
      rd(OFS_RAIL_CONTROL);
      chk_reg("rail_req", 8'h00, got);
      sense = 10'h2A5;
      step(2);
      chk_pin("sense", 10'h2A5, sample);
      end_sim();
   end
endmodule : pmc_misc_regs_tb
